// ### rtl/bbte_cfg.svh
`ifndef BBTE_CFG_SVH
`define BBTE_CFG_SVH
// How it works
// - memory is a linear byte array; rows are byte runs spaced by an offset
// - source and destination row offsets are programmed separately
// - writing the command register starts a transfer; host writes it every time
// - control bit 20 reads back as busy while a transfer runs
// - engine handles byte misalignment between source and destination rows itself
// - vertical bit 1 means top to bottom; horizontal bit 1 means left to right
// - control holds an eight-bit raster op; 0cch is a plain source copy
// - transfer type 00 is screen to screen; other codes take host data
// - low two source address bits give start byte in first host doubleword
// - bytes left in the last host doubleword of a row are discarded
// - next row start byte is previous start plus low two offset bits
// - a host write during a host transfer is taken as source data only while host_ready is high
// - mono bits used bit 7 down to 0, bytes 0 to 3, left to right
// - mono source runs left to right only; the engine forces it whatever the horizontal bit says
// - mono moves to next doubleword after byte 3 bit 0; row end flushes
// - for mono, bytes per line counts expanded destination bytes
// - a three-operand raster unit combines source, destination and 8x8 pattern
`define BBTE_ROP_LSB 0
`define BBTE_INC_Y_BIT 8
`define BBTE_INC_X_BIT 9
`define BBTE_MONO_BIT 11
`define BBTE_TYPE_LSB 14
`define BBTE_BUSY_BIT 20
`define BBTE_ROP_COPY 8'hcc
`define BBTE_TYPE_SCREEN 2'h0
`define BBTE_CTRL_RESET 32'h0000_03cc
`endif

// ### rtl/bbte_pkg.sv
package bbte_pkg;
    // memory request toward display memory
    typedef struct packed {
        logic rd;
        logic wr;
        logic [23:0] addr;
        logic [7:0] wdata;
    } bbte_mem_req_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_SRC,
        ST_RD_DST,
        ST_WRITE,
        ST_WAIT_HOST,
        ST_ROW_END
    } bbte_state_type;
endpackage : bbte_pkg

// ### rtl/bbte_engine.sv
`include "bbte_cfg.svh"
module bbte_engine #(
    parameter int ADDR_W = 24
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register write port, one word per strobe
    input wire logic offset_we,
    input wire logic control_we,
    input wire logic src_addr_we,
    input wire logic dst_addr_we,
    input wire logic command_we,
    input wire logic [31:0] reg_wdata,
    // register read back
    output logic [31:0] blit_control_reg,
    output logic busy,
    // 8x8 pattern byte supplied by the pattern store, indexed by row and column
    output logic [2:0] pat_row,
    output logic [2:0] pat_col,
    input wire logic [7:0] pat_data,
    // mono expansion colours
    input wire logic [7:0] fg_color,
    input wire logic [7:0] bg_color,
    // host source data stream
    input wire logic host_wr,
    input wire logic [31:0] host_wdata,
    output logic host_ready,
    // display memory port, read data valid in the same cycle as mem_ack
    output bbte_pkg::bbte_mem_req_type mem_req,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata
);

    // operating notes for whoever picks this block up next
    //
    // the engine sees display memory as one flat byte space. a transfer is a
    // stack of rows, each row a run of bytes, and each row sits one programmed
    // offset away from the last. nothing here knows about pixels or columns.
    //
    // register writes are plain strobes. control, source and destination are
    // locked while a transfer runs, so a stray write cannot bend a live blit.
    // the offset word is always taken; it is only read at row end.
    //
    // a command write with both halves nonzero is the only thing that starts
    // work. an empty command is dropped without a trace, on purpose: software
    // that polls busy then sees an idle engine and moves on.
    //
    // every destination byte costs a read and a write, even for op codes that
    // ignore the old value. that keeps one path for all 256 ops at the price
    // of bandwidth; a later version could skip the read for source-only ops.
    //
    // memory requests are registered and held until the memory acknowledges.
    // read data is taken in the same cycle as the acknowledge.
    //
    // host-fed transfers wait for one doubleword at a time. host_ready is only
    // raised while no word is held, so a word offered at the wrong moment is
    // never half taken. bytes of the word are used from the start position
    // onward; whatever is left when a row ends is thrown away.
    //
    // mono expansion of host data walks one source bit per destination byte, msb first,
    // and always runs left to right whatever the direction bit says.
    //
    // limitation: the engine does not detect overlap between source and
    // destination. software must pick the direction bits for that case.
    typedef struct packed {
        bbte_pkg::bbte_state_type st;
        logic [31:0] offset;
        logic [31:0] ctrl;
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
        logic [ADDR_W-1:0] src_row;
        logic [ADDR_W-1:0] dst_row;
        logic [15:0] lines;
        logic [15:0] bytes;
        logic [15:0] col;
        logic [1:0] row_start;
        logic [1:0] bidx;
        logic [2:0] bit_i;
        logic have_word;
        logic [31:0] word;
        logic [7:0] sbyte;
        logic [7:0] dbyte;
        bbte_pkg::bbte_mem_req_type req;
    } bbte_state_struct_type;

    bbte_state_struct_type s_reg;
    bbte_state_struct_type s_next;

    // three-operand raster function: each bit picks one entry of the op code
    function automatic logic [7:0] rop3(input logic [7:0] op, input logic [7:0] p,
                                        input logic [7:0] sr, input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = op[{p[i], sr[i], d[i]}];
        end
        return r;
    endfunction : rop3

    // step an address by one byte in the chosen direction
    function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a, input logic up);
        return up ? a + ADDR_W'(1) : a - ADDR_W'(1);
    endfunction : step

    logic inc_x;
    logic inc_y;
    logic mono;
    logic host_src;
    logic [7:0] raster_op_code;
    logic [7:0] src_eff;

    assign raster_op_code = s_reg.ctrl[`BBTE_ROP_LSB +: 8];
    assign inc_y = s_reg.ctrl[`BBTE_INC_Y_BIT];
    // mono is forced left to right whatever the bit says
    assign mono = s_reg.ctrl[`BBTE_MONO_BIT];
    assign inc_x = s_reg.ctrl[`BBTE_INC_X_BIT] | mono;
    assign host_src = s_reg.ctrl[`BBTE_TYPE_LSB +: 2] != `BBTE_TYPE_SCREEN;

    // mono bit consumed msb first from the current byte of the word
    assign src_eff = mono ? (s_reg.sbyte[s_reg.bit_i] ? fg_color : bg_color)
                          : s_reg.sbyte;

    // busy read back in control bit 20
    always_comb begin
        blit_control_reg = s_reg.ctrl;
        blit_control_reg[`BBTE_BUSY_BIT] = s_reg.st != bbte_pkg::ST_IDLE;
    end

    assign busy = s_reg.st != bbte_pkg::ST_IDLE;
    assign mem_req = s_reg.req;
    assign pat_row = s_reg.lines[2:0];
    assign pat_col = s_reg.col[2:0];
    // only ask for a word when none is held, so an offered word is never lost
    assign host_ready = s_reg.st == bbte_pkg::ST_WAIT_HOST && !s_reg.have_word;

    always_comb begin
        s_next = s_reg;
        s_next.req.rd = 1'b0;
        s_next.req.wr = 1'b0;
        if (offset_we) begin
            s_next.offset = reg_wdata;
        end
        if (control_we && s_reg.st == bbte_pkg::ST_IDLE) begin
            s_next.ctrl = reg_wdata;
        end
        if (src_addr_we && s_reg.st == bbte_pkg::ST_IDLE) begin
            s_next.src = reg_wdata[ADDR_W-1:0];
        end
        if (dst_addr_we && s_reg.st == bbte_pkg::ST_IDLE) begin
            s_next.dst = reg_wdata[ADDR_W-1:0];
        end
        unique case (s_reg.st)
            bbte_pkg::ST_IDLE: begin
                // only a command write launches a transfer
                if (command_we && reg_wdata[31:16] != 16'h0000
                        && reg_wdata[15:0] != 16'h0000) begin
                    s_next.lines = reg_wdata[31:16];
                    s_next.bytes = reg_wdata[15:0];
                    s_next.col = 16'h0000;
                    s_next.src_row = s_reg.src;
                    s_next.dst_row = s_reg.dst;
                    s_next.row_start = s_reg.src[1:0];
                    s_next.bidx = s_reg.src[1:0];
                    s_next.bit_i = 3'h7;
                    s_next.have_word = 1'b0;
                    s_next.st = host_src ? bbte_pkg::ST_WAIT_HOST : bbte_pkg::ST_RD_SRC;
                end
            end

            // host source: take a word when none is held, then pick out the
            // byte that the current index points at. the byte goes straight
            // on to the destination read; the word stays for the next bytes.
            bbte_pkg::ST_WAIT_HOST: begin
                if (s_reg.have_word) begin
                    s_next.sbyte = s_reg.word[8*s_reg.bidx +: 8];
                    s_next.st = bbte_pkg::ST_RD_DST;
                end else if (host_wr) begin
                    s_next.word = host_wdata;
                    s_next.have_word = 1'b1;
                end
            end

            // screen source: one byte read per destination byte. the request
            // is raised every cycle and dropped the cycle the answer lands.
            bbte_pkg::ST_RD_SRC: begin
                // screen source: per-byte reads absorb any misalignment
                s_next.req.rd = 1'b1;
                s_next.req.addr = s_reg.src;
                if (s_reg.req.rd && mem_ack) begin
                    s_next.req.rd = 1'b0;
                    s_next.sbyte = mem_rdata;
                    s_next.st = bbte_pkg::ST_RD_DST;
                end
            end

            // destination read: the old byte feeds the raster unit. done for
            // every op code, trading bandwidth for a single data path.
            bbte_pkg::ST_RD_DST: begin
                // destination is always read so every op code works
                s_next.req.rd = 1'b1;
                s_next.req.addr = s_reg.dst;
                if (s_reg.req.rd && mem_ack) begin
                    s_next.req.rd = 1'b0;
                    s_next.dbyte = mem_rdata;
                    s_next.st = bbte_pkg::ST_WRITE;
                end
            end

            // write the combined byte, then step the column and the source
            // pointer. in mono host mode the source pointer is a bit index inside
            // the held byte; a byte is only left once its last bit is used.
            // the column count is in destination bytes for both kinds.
            bbte_pkg::ST_WRITE: begin
                s_next.req.wr = 1'b1;
                s_next.req.addr = s_reg.dst;
                s_next.req.wdata = rop3(raster_op_code, pat_data, src_eff, s_reg.dbyte);
                if (s_reg.req.wr && mem_ack) begin
                    s_next.req.wr = 1'b0;
                    s_next.dst = step(s_reg.dst, inc_x);
                    s_next.col = s_reg.col + 16'h0001;
                    s_next.st = host_src ? bbte_pkg::ST_WAIT_HOST : bbte_pkg::ST_RD_SRC;
                    if (!host_src) begin
                        s_next.src = step(s_reg.src, inc_x);
                    end else if (!mono || s_reg.bit_i == 3'h0) begin
                        // move to the next source byte; new word after byte 3
                        s_next.bit_i = 3'h7;
                        s_next.bidx = 2'(s_reg.bidx + 2'h1);
                        if (s_reg.bidx == 2'h3) begin
                            s_next.have_word = 1'b0;
                        end
                    end else begin
                        s_next.bit_i = s_reg.bit_i - 3'h1;
                    end
                    if (s_reg.col + 16'h0001 == s_reg.bytes) begin
                        s_next.st = bbte_pkg::ST_ROW_END;
                    end
                end
            end

            // one cycle between rows: move both row pointers by their own
            // offset, in the vertical direction chosen, and work out where the
            // next host row starts inside its first word. the last row ends
            // the transfer and drops busy.
            bbte_pkg::ST_ROW_END: begin
                // rows are linear byte runs spaced by their own offset
                s_next.col = 16'h0000;
                s_next.lines = s_reg.lines - 16'h0001;
                s_next.src_row = inc_y ? s_reg.src_row + ADDR_W'(s_reg.offset[15:0])
                                       : s_reg.src_row - ADDR_W'(s_reg.offset[15:0]);
                s_next.dst_row = inc_y ? s_reg.dst_row + ADDR_W'(s_reg.offset[31:16])
                                       : s_reg.dst_row - ADDR_W'(s_reg.offset[31:16]);
                s_next.src = s_next.src_row;
                s_next.dst = s_next.dst_row;
                // leftover bytes or bits of the word are dropped here
                s_next.have_word = 1'b0;
                s_next.row_start = 2'(s_reg.row_start + s_reg.offset[1:0]);
                s_next.bidx = 2'(s_reg.row_start + s_reg.offset[1:0]);
                s_next.bit_i = 3'h7;
                if (s_reg.lines == 16'h0001) begin
                    s_next.st = bbte_pkg::ST_IDLE;
                end else begin
                    s_next.st = host_src ? bbte_pkg::ST_WAIT_HOST : bbte_pkg::ST_RD_SRC;
                end
            end

            // unused state codes fall back to idle
            default: begin
                s_next.st = bbte_pkg::ST_IDLE;
            end
        endcase
    end


    // single state register; reset loads constants only, with the control
    // word at its documented default so a plain copy is ready to go
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.ctrl <= `BBTE_CTRL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : bbte_engine

// ### verification/bbte_asserts.sv
module bbte_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register side
    input wire logic control_we,
    input wire logic command_we,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] blit_control_reg,
    input wire logic busy,
    // data side
    input wire logic host_ready,
    input wire bbte_pkg::bbte_mem_req_type mem_req,
    input wire logic mem_ack
);
    // one domain, so clock and reset are named once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_busy_bit: assert property (blit_control_reg[20] == busy)
        else $error("busy bit differs");
    a_cmd_start: assert property (command_we && !busy && reg_wdata[31:16] != 16'h0
        && reg_wdata[15:0] != 16'h0 |=> busy) else $error("command not started");
    a_zero_size: assert property (command_we && !busy && reg_wdata[15:0] == 16'h0
        |=> !busy) else $error("empty command started");
    a_start_cause: assert property ($rose(busy) |-> $past(command_we))
        else $error("start without command");
    a_req_held: assert property ((mem_req.rd || mem_req.wr) && !mem_ack
        |=> $stable(mem_req)) else $error("request changed before answer");
    a_done_quiet: assert property ($fell(busy) |-> !mem_req.rd && !mem_req.wr)
        else $error("request left after done");
    a_ctrl_write: assert property (control_we && !busy
        |=> blit_control_reg[9:0] == $past(reg_wdata[9:0])) else $error("control not stored");
    a_ctrl_lock: assert property (control_we && busy |=> $stable(blit_control_reg[15:0]))
        else $error("control changed while busy");
    a_host_busy: assert property (host_ready |-> busy)
        else $error("host wait while idle");
endmodule : bbte_asserts

// ### verification/bbte_mem_model.sv
module bbte_mem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // byte port of the engine
    input wire bbte_pkg::bbte_mem_req_type mem_req,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:1023];
    logic slow;
    logic go;
    // flat byte array seeded from the address, so old contents can be recomputed
    initial for (int a = 0; a < 1024; a++) mem[a] = 8'(a * 29 + 91);
    // even addresses may wait a cycle to exercise a held request
    assign go = (mem_req.rd | mem_req.wr) & ~mem_ack & (mem_req.addr[0] | slow);
    // data toggles between answers so a stale byte never looks valid
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            slow <= 1'b0;
            mem_rdata <= 8'h00;
        end else begin
            slow <= ~slow;
            mem_ack <= go;
            mem_rdata <= go ? mem[mem_req.addr[9:0]] : ~mem_rdata;
            if (go & mem_req.wr) mem[mem_req.addr[9:0]] <= mem_req.wdata;
        end
    end
endmodule : bbte_mem_model

// ### verification/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic host_wr = 1'b0;
    logic mono, busy, host_ready, mem_ack;
    logic [4:0] we = 5'h00;
    logic [31:0] reg_wdata = 32'h0, host_wdata = 32'h0, ctl, blit_control_reg;
    logic [31:0] words [0:15];
    logic [7:0] fg_color = 8'h00, bg_color = 8'h00, sv, mem_rdata;
    logic [7:0] snap [0:1023];
    logic [7:0] rops [0:6] = '{8'hcc, 8'h00, 8'hff, 8'h33, 8'h66, 8'h88, 8'hf0};
    logic [2:0] pat_row, pat_col;
    bbte_pkg::bbte_mem_req_type mem_req;
    int fails = 0, num_checks = 0, seed = 3, k = 0;
    int lines, nb, src, dst, soff, doff, st, wb, idx, da, x, y, t;
    // constant pattern byte: the pattern store is outside this block
    bbte_engine bbte_engine_i (.clk_sys, .rst, .offset_we(we[4]), .control_we(we[3]),
        .src_addr_we(we[2]), .dst_addr_we(we[1]), .command_we(we[0]), .reg_wdata,
        .blit_control_reg, .busy, .pat_row, .pat_col, .pat_data(8'ha5), .fg_color,
        .bg_color, .host_wr, .host_wdata, .host_ready, .mem_req, .mem_ack, .mem_rdata);
    bbte_mem_model bbte_mem_model_i (.clk_sys, .rst, .mem_req, .mem_ack, .mem_rdata);
    initial forever #5 clk_sys = ~clk_sys;
    // host sends the next word while the engine waits, idling a cycle between words
    always @(posedge clk_sys) begin
        if (host_wr & host_ready) k = k + 1;
        host_wr <= host_ready & ~host_wr;
        host_wdata <= words[k];
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one strobe per write; the short delay lets the write land before anyone looks
    task automatic wr(input logic [2:0] sel, input logic [31:0] d);
        @(posedge clk_sys);
        we <= 5'h10 >> sel;
        reg_wdata <= d;
        @(posedge clk_sys);
        we <= 5'h00;
        #1;
    endtask : wr
    function automatic logic [7:0] rop_f(input logic [7:0] op, p, s, d);
        for (int b = 0; b < 8; b++)
            rop_f[b] = op[{p[b], s[b], d[b]}];
    endfunction : rop_f
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        wr(3'h4, 32'h0003_0000); // empty line is refused
        chk("control reset", blit_control_reg, 32'h0000_03cc);
        for (int i = 0; i < 14; i++) begin
            @(posedge clk_sys);
            mono = i > 10;
            ctl = {16'h0, 2'(i > 7), 2'h0, mono, 1'b0, 1'($random(seed)) | (i > 7 && !mono),
                1'($random(seed)), rops[i % 7]};
            fg_color <= 8'($random(seed));
            bg_color <= 8'($random(seed));
            lines = i == 0 ? 3 : 1 + {$random(seed)} % 3;
            nb = mono ? 20 + {$random(seed)} % 20 : 1 + {$random(seed)} % 5;
            soff = 8 + {$random(seed)} % 32;
            // mono rows are long, so keep destination rows apart
            doff = (mono ? 40 : 8) + {$random(seed)} % 32;
            src = 150 + {$random(seed)} % 64;
            dst = 662 + {$random(seed)} % 64;
            for (int w = 0; w < 16; w++)
                words[w] = $random(seed);
            snap = bbte_mem_model_i.mem;
            k = 0;
            wr(3'h0, {16'(doff), 16'(soff)});
            wr(3'h1, ctl);
            wr(3'h2, src);
            wr(3'h3, dst);
            wr(3'h4, {16'(lines), 16'(nb)});
            wr(3'h1, 32'h0); // ignored while busy
            // memory is only looked at once the engine is idle
            for (t = 0; t < 9000 && busy !== 1'b0; t++) begin
                @(posedge clk_sys);
                #1;
            end
            if (t == 9000) fails++;
            if (t == 9000) end_of_test();
            chk("control kept", blit_control_reg & 32'hffff, ctl & 32'hffff);
            st = src % 4;
            wb = 0;
            for (int r = 0; r < lines; r++) begin
                for (int c = 0; c < nb; c++) begin
                    y = ctl[8] ? r : -r;
                    x = ctl[9] | mono ? c : -c;
                    idx = st * 8 + c * (mono ? 1 : 8);
                    sv = 8'(words[wb + idx / 32] >> (idx % 32 / 8 * 8));
                    if (mono) sv = sv[7 - idx % 8] ? fg_color : bg_color;
                    if (ctl[15:14] == 2'h0) sv = snap[src + y * soff + x];
                    da = dst + y * doff + x;
                    chk("dest byte", 32'(bbte_mem_model_i.mem[da]),
                        32'(rop_f(ctl[7:0], 8'ha5, sv, snap[da])));
                end
                wb += (st * 8 + nb * (mono ? 1 : 8) + 31) / 32;
                st = (st + soff) % 4;
            end
            $display("test %0d done", i);
        end
        end_of_test();
    end
endmodule : tb
bind bbte_engine bbte_asserts bbte_asserts_i (.clk_sys, .rst, .control_we, .command_we,
    .reg_wdata, .blit_control_reg, .busy, .host_ready, .mem_req, .mem_ack);
